// *** plkgr_pkg.sv ***
// package: register map, field positions, reset values and shared types
package plkgr_pkg;
    localparam int          REG_AW           = 6;
    localparam int          REG_DW           = 24;
    localparam logic [5:0]  OFF_AUXMOD_B     = 6'h19;
    localparam logic [5:0]  OFF_LOCK_WIN     = 6'h1A;
    localparam logic [5:0]  OFF_GPO_CTRL     = 6'h1B;
    localparam logic [5:0]  OFF_SLIP_CTRL    = 6'h1C;
    localparam logic [5:0]  OFF_SPARE_1D     = 6'h1D;
    localparam logic [5:0]  OFF_THERM_EN     = 6'h1E;
    localparam logic [5:0]  OFF_STATUS       = 6'h1F;
    localparam logic [5:0]  OFF_SPARE_20     = 6'h20;
    localparam logic [5:0]  OFF_THERM_RD     = 6'h21;
    localparam logic [5:0]  OFF_SPARE_22     = 6'h22;
    // field positions
    localparam int          AUX_HIDLY_LSB    = 0;
    localparam int          AUX_CLKINV_BIT   = 3;
    localparam int          AUX_RINGCLK_BIT  = 4;
    localparam int          LK_CNT_LSB       = 0;
    localparam int          LK_ASYM_EN_BIT   = 10;
    localparam int          LK_ASYM_POL_BIT  = 11;
    localparam int          LK_AUTO_BIT      = 12;
    localparam int          LK_FORCED_BIT    = 13;
    localparam int          LK_RINGSEL_BIT   = 14;
    localparam int          LK_RINGCFG_LSB   = 15;
    localparam int          LK_MONO_LSB      = 17;
    localparam int          LK_RINGTEST_BIT  = 19;
    localparam int          GPO_SEL_LSB      = 0;
    localparam int          GPO_DATA_LSB     = 4;
    localparam int          GPO_DRV_EN_BIT   = 7;
    localparam int          GPO_DIS_LSB      = 8;
    localparam int          SLIP_STEP_LSB    = 0;
    localparam int          SLIP_FORCE_BIT   = 4;
    localparam int          SLIP_RSTB_BIT    = 5;
    localparam int          STAT_OVF_LSB     = 1;
    localparam int          STAT_BUSY_BIT    = 5;
    // reset values
    localparam logic [23:0] RST_AUXMOD_B     = 24'h00000F;
    localparam logic [23:0] RST_LOCK_WIN     = 24'h001040;
    localparam logic [23:0] RST_GPO_CTRL     = 24'h000000;
    localparam logic [23:0] RST_SLIP_CTRL    = 24'h000020;
    localparam logic [23:0] RST_SPARE_1D     = 24'h000000;
    localparam logic [23:0] RST_THERM_EN     = 24'h000000;
    localparam logic [23:0] VAL_SPARE_20     = 24'h000020;
    localparam logic [23:0] VAL_SPARE_22     = 24'h000000;
    localparam logic [6:0]  THERM_CODE_MAX   = 7'h07;
    // gpo select codes
    localparam logic [3:0]  GSEL_SOFT        = 4'h0;
    localparam logic [3:0]  GSEL_CLOCKS      = 4'h1;
    localparam logic [3:0]  GSEL_PFD         = 4'h2;
    localparam logic [3:0]  GSEL_SAT         = 4'h3;
    localparam logic [3:0]  GSEL_XREF        = 4'h4;
    localparam logic [3:0]  GSEL_RSV5        = 4'h5;
    localparam logic [3:0]  GSEL_PHASE       = 4'h6;
    localparam logic [3:0]  GSEL_AUX         = 4'h7;
    localparam logic [3:0]  GSEL_BUSY        = 4'h8;
    localparam logic [3:0]  GSEL_RSV9        = 4'h9;
    localparam logic [3:0]  GSEL_QUANT       = 4'hA;

    typedef enum logic [1:0] {PLKGR_IDLE, PLKGR_RD, PLKGR_WR} plkgr_bus_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [23:0] wdata;
    } plkgr_req_t;

    // internal sources offered to the output multiplexer
    typedef struct packed {
        logic       xref_clk;
        logic       ref_clk;
        logic       vco_div_clk;
        logic       pfd_up;
        logic       pfd_dn;
        logic       lock_window;
        logic       sat_ref;
        logic       sat_vco;
        logic       slip_gain_strobe;
        logic       xref_sine;
        logic       frac_update_pulse_synced;
        logic [2:0] integ_phase;
        logic       aux_clk;
        logic       ring_test;
        logic       mod_clk;
        logic       sweep_busy;
        logic [2:0] quant_lsbs;
    } plkgr_src_t;

    typedef struct packed {
        logic [23:0] auxmod_b;
        logic [23:0] lock_win;
        logic [23:0] gpo_ctrl;
        logic [23:0] slip_ctrl;
        logic [23:0] spare_1d;
        logic [23:0] therm_en;
        logic [23:0] rdata;
        logic        rvalid;
    } plkgr_state_t;
endpackage

// *** plkgr_gpo_mux.sv ***
// output pin multiplexer and pad driver enables
`timescale 1ns/1ps
`default_nettype none
module plkgr_gpo_mux
    import plkgr_pkg::*;
(
    input  wire logic [3:0] sel,
    input  wire logic [2:0] soft_data,
    input  wire logic       drive_en,
    input  wire logic [2:0] drive_dis,
    input  wire plkgr_src_t src,
    output logic      [2:0] pin_o,
    output logic      [2:0] pin_oe
);
    logic [2:0] v;
    // index 2 is output 3, index 0 is output 1
    always_comb begin
        case (sel)
            GSEL_SOFT:   v = soft_data;
            GSEL_CLOCKS: v = {src.xref_clk, src.ref_clk, src.vco_div_clk};
            GSEL_PFD:    v = {src.pfd_up, src.pfd_dn, src.lock_window};
            GSEL_SAT:    v = {src.sat_ref, src.sat_vco, src.slip_gain_strobe};
            GSEL_XREF:   v = {src.xref_clk, src.xref_sine, src.frac_update_pulse_synced};
            GSEL_PHASE:  v = src.integ_phase;
            GSEL_AUX:    v = {src.aux_clk, src.ring_test, src.mod_clk};
            GSEL_BUSY:   v = {1'b0, src.sweep_busy, 1'b0};
            GSEL_QUANT:  v = src.quant_lsbs;
            default:     v = 3'h0;
        endcase
    end

    assign pin_o = v;

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_pad
            assign pin_oe[i] = drive_en & ~drive_dis[i];
        end
    endgenerate
endmodule
`default_nettype wire

// *** plkgr_therm_code.sv ***
// temperature to 7-bit code conversion with saturation
`timescale 1ns/1ps
`default_nettype none
module plkgr_therm_code
    import plkgr_pkg::*;
(
    input  wire logic signed [11:0] temp_c10,
    output logic             [6:0]  code
);
    // temperature in tenths of a degree; step is 175 tenths, offset 400
    // input range reaches past the top code, so the high saturation is live
    logic signed [12:0] shifted;
    always_comb begin
        shifted = 13'(temp_c10) + 13'sd400;
        if (shifted < 13'sd0) begin
            code = 7'h00;
        end else if (shifted >= 13'sd1225) begin
            code = THERM_CODE_MAX;
        end else begin
            code = 7'(shifted / 13'sd175);
        end
    end
endmodule
`default_nettype wire

// *** plkgr_regs.sv ***
// register bank: aux modulator, lock window, output pins, slip guard, thermal, status
//
// Notes on behaviour
// - high delay value, three bits, defaults seven
// - invert modulator aux clock, default inverted
// - select ring oscillator clocking the shift generator
// - lock declared at programmable count, default 40h
// - asymmetric window enable and its polarity
// - auto route lock onto idle serial out
// - forced lock route; host then skips reads
// - one-shot source, ring speed, duration fields
// - ring oscillator test bit, default off
// - select zero drives pins from software bits
// - codes one, two route clocks, detector
// - code three routes saturation and slip strobe
// - code four routes reference, sine, frac pulse
// - code six integrator phase; five, nine reserved
// - codes seven, eight, ten: aux, busy, quantizer
// - pad drivers need enable; per-pin disables
// - slip step field, polarity bit, zero disables
// - force bit picks manual or automatic reset
// - manual reset bit enables guard, default one
// - status: lock, overflow, sweep busy bits
// - thermal code floor((T+40)/17.5), saturating
`timescale 1ns/1ps
`default_nettype none
module plkgr_regs
    import plkgr_pkg::*;
#(
    parameter int LOCK_CNT_W = 10
)
(
    input  wire logic              CLK,
    input  wire logic              RST,
    // register port of the main serial interface
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    input  wire logic [5:0]        REG_ADDR,
    input  wire logic [23:0]       REG_WDATA,
    output logic      [23:0]       REG_RDATA,
    output logic                   REG_RVALID,
    input  wire logic              READ_ACTIVE,
    input  wire logic              READ_DATA_BIT,
    output logic                   SERIAL_OUT,
    // lock detector inputs
    input  wire logic              PHASE_IN_WINDOW,
    input  wire logic              REF_CYCLE,
    // internal sources for the output pins, status word and thermal code
    input  wire plkgr_src_t        GPO_SRC,
    input  wire logic [2:0]        MODULATOR_OVERFLOW,
    input  wire logic signed [11:0] TEMP_C10,
    // general output pins
    output logic      [2:0]        GPO_O,
    output logic      [2:0]        GPO_OE,
    // decoded controls to the analog side
    output logic      [2:0]        AUX_HI_DELAY,
    output logic                   AUX_CLK_INVERT,
    output logic                   AUX_RING_CLOCKS_LFSR,
    output logic                   LOCK_ASYM_EN,
    output logic                   LOCK_ASYM_POL,
    output logic                   LOCK_RING_ONESHOT,
    output logic      [1:0]        LOCK_RING_SPEED,
    output logic      [1:0]        LOCK_ONESHOT_LEN,
    output logic                   LOCK_RING_TEST,
    output logic                   SLIP_ADVANCE_EN,
    output logic                   SLIP_POLARITY,
    output logic      [2:0]        SLIP_MAGNITUDE,
    output logic                   PFD_RESET_N,
    input  wire logic              SLIP_AUTO_RESET_N,
    output logic                   THERM_ENABLE,
    output logic                   LOCKED
);
    plkgr_state_t s_q;
    plkgr_state_t s_d;
    logic [LOCK_CNT_W-1:0] win_cnt_q;
    logic [LOCK_CNT_W-1:0] win_cnt_d;
    logic                  locked_q;
    logic                  locked_d;
    logic [6:0]            therm_code;
    logic [23:0]           status_word;
    logic [LOCK_CNT_W-1:0] lock_target;

    plkgr_therm_code i_plkgr_therm_code (
        .temp_c10 (TEMP_C10),
        .code     (therm_code)
    );

    plkgr_gpo_mux i_plkgr_gpo_mux (
        .sel       (s_q.gpo_ctrl[GPO_SEL_LSB +: 4]),
        .soft_data (s_q.gpo_ctrl[GPO_DATA_LSB +: 3]),
        .drive_en  (s_q.gpo_ctrl[GPO_DRV_EN_BIT]),
        .drive_dis (s_q.gpo_ctrl[GPO_DIS_LSB +: 3]),
        .src       (GPO_SRC),
        .pin_o     (GPO_O),
        .pin_oe    (GPO_OE)
    );

    assign lock_target = s_q.lock_win[LK_CNT_LSB +: LOCK_CNT_W];

    always_comb begin
        status_word                = 24'h0;
        status_word[0]             = locked_q;
        status_word[STAT_OVF_LSB +: 3] = MODULATOR_OVERFLOW;
        status_word[STAT_BUSY_BIT] = GPO_SRC.sweep_busy;
    end

    // register write and read path
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        if (REG_WR) begin
            case (REG_ADDR)
                OFF_AUXMOD_B:  s_d.auxmod_b  = {19'h0, REG_WDATA[4:0]};
                OFF_LOCK_WIN:  s_d.lock_win  = {4'h0, REG_WDATA[19:0]};
                OFF_GPO_CTRL:  s_d.gpo_ctrl  = {13'h0, REG_WDATA[10:0]};
                OFF_SLIP_CTRL: s_d.slip_ctrl = {18'h0, REG_WDATA[5:0]};
                OFF_SPARE_1D:  s_d.spare_1d  = REG_WDATA;
                OFF_THERM_EN:  s_d.therm_en  = {23'h0, REG_WDATA[0]};
                default:       s_d.spare_1d  = s_q.spare_1d;
            endcase
        end
        if (REG_RD) begin
            s_d.rvalid = 1'b1;
            case (REG_ADDR)
                OFF_AUXMOD_B:  s_d.rdata = s_q.auxmod_b;
                OFF_LOCK_WIN:  s_d.rdata = s_q.lock_win;
                OFF_GPO_CTRL:  s_d.rdata = s_q.gpo_ctrl;
                OFF_SLIP_CTRL: s_d.rdata = s_q.slip_ctrl;
                OFF_SPARE_1D:  s_d.rdata = s_q.spare_1d;
                OFF_THERM_EN:  s_d.rdata = s_q.therm_en;
                OFF_STATUS:    s_d.rdata = status_word;
                OFF_SPARE_20:  s_d.rdata = VAL_SPARE_20;
                OFF_THERM_RD:  s_d.rdata = {17'h0, therm_code};
                OFF_SPARE_22:  s_d.rdata = VAL_SPARE_22;
                default:       s_d.rdata = 24'h0;
            endcase
        end
    end

    // lock counter: counts reference cycles in window, restarts on a miss
    always_comb begin
        win_cnt_d = win_cnt_q;
        locked_d  = locked_q;
        if (REF_CYCLE) begin
            if (!PHASE_IN_WINDOW) begin
                win_cnt_d = '0;
                locked_d  = 1'b0;
            end else if (win_cnt_q >= lock_target - LOCK_CNT_W'(1)) begin
                locked_d  = 1'b1;
            end else begin
                win_cnt_d = win_cnt_q + LOCK_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q.auxmod_b  <= RST_AUXMOD_B;
            s_q.lock_win  <= RST_LOCK_WIN;
            s_q.gpo_ctrl  <= RST_GPO_CTRL;
            s_q.slip_ctrl <= RST_SLIP_CTRL;
            s_q.spare_1d  <= RST_SPARE_1D;
            s_q.therm_en  <= RST_THERM_EN;
            s_q.rdata     <= 24'h0;
            s_q.rvalid    <= 1'b0;
            win_cnt_q     <= '0;
            locked_q      <= 1'b0;
        end else begin
            s_q       <= s_d;
            win_cnt_q <= win_cnt_d;
            locked_q  <= locked_d;
        end
    end

    assign REG_RDATA  = s_q.rdata;
    assign REG_RVALID = s_q.rvalid;
    assign LOCKED     = locked_q;

    // serial data output sharing
    always_comb begin
        if (s_q.lock_win[LK_FORCED_BIT]) begin
            SERIAL_OUT = locked_q;
        end else if (READ_ACTIVE) begin
            SERIAL_OUT = READ_DATA_BIT;
        end else if (s_q.lock_win[LK_AUTO_BIT]) begin
            SERIAL_OUT = locked_q;
        end else begin
            SERIAL_OUT = 1'b0;
        end
    end

    assign AUX_HI_DELAY         = s_q.auxmod_b[AUX_HIDLY_LSB +: 3];
    assign AUX_CLK_INVERT       = s_q.auxmod_b[AUX_CLKINV_BIT];
    assign AUX_RING_CLOCKS_LFSR = s_q.auxmod_b[AUX_RINGCLK_BIT];
    assign LOCK_ASYM_EN         = s_q.lock_win[LK_ASYM_EN_BIT];
    assign LOCK_ASYM_POL        = s_q.lock_win[LK_ASYM_POL_BIT];
    assign LOCK_RING_ONESHOT    = s_q.lock_win[LK_RINGSEL_BIT];
    assign LOCK_RING_SPEED      = s_q.lock_win[LK_RINGCFG_LSB +: 2];
    assign LOCK_ONESHOT_LEN     = s_q.lock_win[LK_MONO_LSB +: 2];
    assign LOCK_RING_TEST       = s_q.lock_win[LK_RINGTEST_BIT];
    // slip guard step: zero disables, top field bit is polarity
    assign SLIP_ADVANCE_EN      = (s_q.slip_ctrl[SLIP_STEP_LSB +: 4] != 4'h0)
                                  & s_q.slip_ctrl[SLIP_RSTB_BIT];
    assign SLIP_POLARITY        = s_q.slip_ctrl[SLIP_STEP_LSB + 3];
    assign SLIP_MAGNITUDE       = s_q.slip_ctrl[SLIP_STEP_LSB +: 3];
    assign PFD_RESET_N          = s_q.slip_ctrl[SLIP_FORCE_BIT] ? s_q.slip_ctrl[SLIP_RSTB_BIT]
                                                                : SLIP_AUTO_RESET_N;
    assign THERM_ENABLE         = s_q.therm_en[0];
endmodule
`default_nettype wire

// *** plkgr_regs_assertions.sv ***
// checker: port-level timing relations of the register bank
`timescale 1ns/1ps
`default_nettype none
module plkgr_regs_assertions
    import plkgr_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic       REG_RVALID,
    input  wire logic       READ_ACTIVE,
    input  wire logic       READ_DATA_BIT,
    input  wire logic       SERIAL_OUT,
    input  wire logic       REF_CYCLE,
    input  wire logic       PHASE_IN_WINDOW,
    input  wire logic       LOCKED,
    input  wire logic [2:0] GPO_OE,
    input  wire logic [2:0] AUX_HI_DELAY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    read_answer_a: assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
    answer_cause_a: assert property (REG_RVALID |-> $past(REG_RD)) else $error("stray read valid");
    lock_drop_a: assert property (REF_CYCLE && !PHASE_IN_WINDOW |=> !LOCKED) else $error("lock kept");
    lock_steady_a: assert property (!REF_CYCLE |=> $stable(LOCKED)) else $error("lock moved");
    lock_rise_a: assert property ($rose(LOCKED) |-> $past(REF_CYCLE && PHASE_IN_WINDOW)) else $error("bad lock");
    serial_idle_a: assert property (!READ_ACTIVE && !LOCKED |-> !SERIAL_OUT) else $error("serial out high");
    serial_read_a: assert property (READ_ACTIVE && SERIAL_OUT |-> READ_DATA_BIT || LOCKED) else $error("bad bit");
    oe_hold_a: assert property (!$past(REG_WR) |-> $stable(GPO_OE)) else $error("pad enable moved");
    delay_hold_a: assert property (!$past(REG_WR) |-> $stable(AUX_HI_DELAY)) else $error("delay moved");
    cover property ($rose(LOCKED));
    cover property (REG_RD ##1 REG_RVALID);
    cover property (READ_ACTIVE && SERIAL_OUT);
endmodule
bind plkgr_regs plkgr_regs_assertions i_plkgr_regs_assertions (.CLK(CLK), .RST(RST), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RVALID(REG_RVALID), .READ_ACTIVE(READ_ACTIVE), .READ_DATA_BIT(READ_DATA_BIT),
    .SERIAL_OUT(SERIAL_OUT), .REF_CYCLE(REF_CYCLE), .PHASE_IN_WINDOW(PHASE_IN_WINDOW), .LOCKED(LOCKED),
    .GPO_OE(GPO_OE), .AUX_HI_DELAY(AUX_HI_DELAY));
`default_nettype wire

// *** plkgr_host_model.sv ***
// host model: register accesses over the serial port's register interface
`timescale 1ns/1ps
`default_nettype none
module plkgr_host_model
    import plkgr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [23:0] rdata,
    input  wire logic        rvalid,
    output var  logic        wr,
    output var  logic        rd,
    output var  logic [5:0]  addr,
    output var  logic [23:0] wdata
);
    logic forced_q = 1'b0;
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 6'h00;
        wdata = 24'h000000;
    end
    // released lines show the inverse of the last value
    task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk);
        #1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        if (a == OFF_LOCK_WIN) begin
            forced_q = d[LK_FORCED_BIT];
        end
        @(posedge clk);
        #1;
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [23:0] d, output logic ok);
        d = 24'h000000;
        ok = 1'b0;
        // no reads while lock is forced onto serial out
        if (!forced_q) begin
            @(posedge clk);
            #1;
            rd = 1'b1;
            addr = a;
            @(posedge clk);
            #1;
            rd = 1'b0;
            addr = ~a;
            d = rdata;
            ok = rvalid;
        end
    endtask
endmodule
`default_nettype wire

// *** plkgr_regs_bench.sv ***
// self-checking bench of the register bank
`timescale 1ns/1ps
`default_nettype none
module plkgr_regs_bench;
    import plkgr_pkg::*;
    logic              clk = 1'b0, rst = 1'b1, read_active = 1'b0, read_bit = 1'b0;
    logic              phase_in = 1'b0, ref_cycle = 1'b0, auto_rst_n = 1'b1;
    logic              wr, rd, rvalid, serial_out, ring_lfsr, asym_en, asym_pol, ring_sel, ring_test;
    logic              slip_en, slip_pol, pfd_rst_n, clk_inv, therm_en, locked, ok;
    logic [1:0]        ring_speed, mono_len;
    logic [2:0]        hi_dly, gpo_o, gpo_oe, slip_mag;
    logic [5:0]        addr;
    logic [23:0]       wdata, rdata, seen;
    logic signed [11:0] temp = 12'sd0;
    logic [2:0]        ovf = 3'h5;
    plkgr_src_t        src = 21'b101011110000100011111;
    int                failures = 0;
    int                checks_done = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    plkgr_regs i_plkgr_regs (.CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .READ_ACTIVE(read_active),
        .READ_DATA_BIT(read_bit), .SERIAL_OUT(serial_out), .PHASE_IN_WINDOW(phase_in), .REF_CYCLE(ref_cycle),
        .GPO_SRC(src), .MODULATOR_OVERFLOW(ovf), .TEMP_C10(temp), .GPO_O(gpo_o), .GPO_OE(gpo_oe),
        .AUX_HI_DELAY(hi_dly), .AUX_CLK_INVERT(clk_inv), .AUX_RING_CLOCKS_LFSR(ring_lfsr),
        .LOCK_ASYM_EN(asym_en), .LOCK_ASYM_POL(asym_pol), .LOCK_RING_ONESHOT(ring_sel),
        .LOCK_RING_SPEED(ring_speed), .LOCK_ONESHOT_LEN(mono_len), .LOCK_RING_TEST(ring_test),
        .SLIP_ADVANCE_EN(slip_en), .SLIP_POLARITY(slip_pol), .SLIP_MAGNITUDE(slip_mag),
        .PFD_RESET_N(pfd_rst_n), .SLIP_AUTO_RESET_N(auto_rst_n), .THERM_ENABLE(therm_en), .LOCKED(locked));
    plkgr_host_model i_plkgr_host_model (.clk(clk), .rdata(rdata), .rvalid(rvalid), .wr(wr), .rd(rd),
        .addr(addr), .wdata(wdata));
    task automatic chk(input string name, input logic [23:0] got, input logic [23:0] want);
        checks_done++;
        if (got !== want) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, want, got);
        end
    endtask
    task automatic wr_w(input logic [5:0] a, input logic [23:0] d);
        i_plkgr_host_model.wr_reg(a, d);
    endtask
    task automatic rd_chk(input string name, input logic [5:0] a, input logic [23:0] want);
        i_plkgr_host_model.rd_reg(a, seen, ok);
        chk({name, " valid"}, {23'h0, ok}, 24'h000001);
        chk(name, seen, want);
    endtask
    task automatic pulse_ref(input logic in_win);
        @(posedge clk);
        #1;
        ref_cycle = 1'b1;
        phase_in = in_win;
        @(posedge clk);
        #1;
        ref_cycle = 1'b0;
    endtask
    task automatic test_reset_values();
        logic [23:0] want [11] = '{24'h00000F, 24'h001040, 24'h0, 24'h000020, 24'h0, 24'h0,
                                   24'h00002A, 24'h000020, 24'h000002, 24'h0, 24'h0};
        for (int i = 0; i < 11; i++) begin
            rd_chk("reset value", 6'h19 + 6'(i), want[i]);
        end
        wr_w(OFF_STATUS, 24'hFFFFFF);
        wr_w(OFF_SPARE_20, 24'hFFFFFF);
        wr_w(OFF_SPARE_1D, 24'hA5A5A5);
        rd_chk("status ro", OFF_STATUS, 24'h00002A);
        rd_chk("spare ro", OFF_SPARE_20, 24'h000020);
        rd_chk("spare rw", OFF_SPARE_1D, 24'hA5A5A5);
    endtask
    task automatic test_controls();
        chk("aux reset", {19'h0, ring_lfsr, clk_inv, hi_dly}, 24'h00000F);
        wr_w(OFF_AUXMOD_B, 24'h000010);
        chk("aux ctl", {19'h0, ring_lfsr, clk_inv, hi_dly}, 24'h000010);
        wr_w(OFF_LOCK_WIN, 24'h0FDC00);
        chk("lock ctl", {16'h0, ring_test, mono_len, ring_speed, ring_sel, asym_pol, asym_en}, 24'h0000FF);
        rd_chk("lock readback", OFF_LOCK_WIN, 24'h0FDC00);
    endtask
    task automatic test_lock_route();
        wr_w(OFF_LOCK_WIN, 24'h001003);
        pulse_ref(1'b1);
        pulse_ref(1'b1);
        chk("early lock", {23'h0, locked}, 24'h0);
        pulse_ref(1'b1);
        chk("lock", {23'h0, locked}, 24'h1);
        chk("auto route", {23'h0, serial_out}, 24'h1);
        read_active = 1'b1;
        #1;
        chk("read bit route", {23'h0, serial_out}, 24'h0);
        ovf = 3'h4;
        src.sweep_busy = 1'b0;
        rd_chk("locked status", OFF_STATUS, 24'h000009);
        src.sweep_busy = 1'b1;
        wr_w(OFF_LOCK_WIN, 24'h002003);
        chk("forced route", {23'h0, serial_out}, 24'h1);
        pulse_ref(1'b0);
        chk("lock lost", {23'h0, locked}, 24'h0);
        wr_w(OFF_LOCK_WIN, 24'h000003);
        read_active = 1'b0;
        repeat (3) pulse_ref(1'b1);
        chk("no route", {22'h0, locked, serial_out}, 24'h2);
        read_active = 1'b1;
        read_bit = 1'b1;
        #1;
        chk("read bit one", {23'h0, serial_out}, 24'h1);
        read_active = 1'b0;
        read_bit = 1'b0;
    endtask
    task automatic test_gpo();
        logic [2:0] want [12] = '{3'b110, 3'b101, 3'b011, 3'b110, 3'b100, 3'b000,
                                  3'b010, 3'b001, 3'b010, 3'b000, 3'b111, 3'b000};
        for (int i = 0; i < 12; i++) begin
            wr_w(OFF_GPO_CTRL, {13'h0, 3'b010, 1'b1, 3'b110, 4'(i)});
            chk("gpo pins", {21'h0, gpo_o}, {21'h0, want[i]});
            chk("gpo enables", {21'h0, gpo_oe}, 24'h000005);
        end
        wr_w(OFF_GPO_CTRL, 24'h000700);
        chk("pads off", {21'h0, gpo_oe}, 24'h0);
        wr_w(OFF_GPO_CTRL, 24'h000080);
        chk("pads on", {21'h0, gpo_oe}, 24'h000007);
    endtask
    task automatic test_slip();
        logic [23:0] ctl [4] = '{24'h000010, 24'h000030, 24'h00002F, 24'h00000F};
        logic [23:0] want [4] = '{24'h0, 24'h000020, 24'h00003F, 24'h00002F};
        for (int i = 0; i < 4; i++) begin
            wr_w(OFF_SLIP_CTRL, ctl[i]);
            chk("slip", {18'h0, pfd_rst_n, slip_en, slip_pol, slip_mag}, want[i]);
        end
        wr_w(OFF_SLIP_CTRL, 24'h00002F);
        auto_rst_n = 1'b0;
        #1;
        chk("auto reset", {23'h0, pfd_rst_n}, 24'h0);
        @(posedge clk);
        #1;
        auto_rst_n = 1'b1;
    endtask
    task automatic test_thermal();
        logic signed [11:0] t [10] = '{-12'sd512, -12'sd401, -12'sd400, -12'sd226, -12'sd225, 12'sd0, 12'sd475,
                                       12'sd824, 12'sd825, 12'sd2047};
        logic [23:0] want [10] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h1, 24'h2, 24'h5, 24'h6, 24'h7, 24'h7};
        wr_w(OFF_THERM_EN, 24'h000001);
        chk("thermal enable", {23'h0, therm_en}, 24'h1);
        for (int i = 0; i < 10; i++) begin
            temp = t[i];
            rd_chk("thermal code", OFF_THERM_RD, want[i]);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        test_reset_values();
        test_controls();
        test_lock_route();
        test_gpo();
        test_slip();
        test_thermal();
        print_verdict();
    end
endmodule
`default_nettype wire
